// >>> verilog/gdac_update_control.sv
// Gamma DAC update control: two-wire slave, pointer decode and double-buffered channel codes.
// Assumes the data line is resolved outside,
// an external master clocks the link,
// converters turn each code into a level.
`timescale 1ns/100ps
`include "gdac_regs.svh"

module gdac_update_control #(
    parameter logic [7:0] DEV_ADDR = `GDAC_DEV_ADDR     // Write address byte
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    input  wire logic                  i_latch_load_pin,
    output logic                       o_sda_o,
    output logic                       o_sda_oe,
    output gdac_pkg::gdac_bank_type    o_dac_code
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    gdac_pkg::gdac_link_type   link;          // Synchronised link events

    gdac_pkg::gdac_state_type  state;         // Bit-level state
    gdac_pkg::gdac_state_type  next_state;    // Its next value
    gdac_pkg::gdac_phase_type  phase;         // Role of current byte
    gdac_pkg::gdac_phase_type  next_phase;    // Role after the ack

    logic [3:0]                bit_cnt;       // Bits received in this byte
    logic [7:0]                shift;         // Incoming byte, MSB first

    logic [7:0]                pointer;       // Last pointer byte, index advances
    logic [7:0]                msb_byte;      // High byte awaiting its low byte

    logic                      sda_oe;        // Ack drive

    gdac_pkg::gdac_bank_type   store;         // Storage registers
    gdac_pkg::gdac_bank_type   outreg;        // Output registers

    ////////////////////////////////////////////////////////////////////////////
    // Pin front end

    gdac_link_rx u_link_rx (
        .i_ref_clk        (i_ref_clk),
        .i_rst            (i_rst),
        .i_scl            (i_scl),
        .i_sda            (i_sda),
        .i_latch_load_pin (i_latch_load_pin),
        .o_link           (link)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Byte decode: decisions are taken on the clock fall
    // that ends the eighth bit,
    // when the ack must start.

    // Eighth bit in and the clock just fell
    wire byte_end = (state == gdac_pkg::GDAC_ST_RX) & link.scl_fall & (bit_cnt == `GDAC_BYTE_BITS);

    // Phase tests
    wire ph_addr = (phase == gdac_pkg::GDAC_PH_ADDR);
    wire ph_gc   = (phase == gdac_pkg::GDAC_PH_GC);
    wire ph_ptr  = (phase == gdac_pkg::GDAC_PH_PTR);
    wire ph_msb  = (phase == gdac_pkg::GDAC_PH_MSB);
    wire ph_lsb  = (phase == gdac_pkg::GDAC_PH_LSB);

    // Address matches; reads are not served
    wire addr_dev = (shift == DEV_ADDR);
    wire addr_gc  = (shift == `GDAC_GC_ADDR);
    wire gc_ok    = (shift == `GDAC_GC_RESET);

    // Pointer fields of the byte now complete
    wire [2:0] new_cmd = shift[`GDAC_CMD_HI:`GDAC_CMD_LO];
    wire [4:0] new_sel = shift[`GDAC_SEL_HI:0];
    wire       new_ok  = (new_sel < 5'(`GDAC_CHANNELS));

    // Fields of the stored pointer, used for data writes
    wire [2:0] ptr_cmd = pointer[`GDAC_CMD_HI:`GDAC_CMD_LO];
    wire [4:0] ptr_sel = pointer[`GDAC_SEL_HI:0];
    wire       ptr_ok  = (ptr_sel < 5'(`GDAC_CHANNELS));

    // Reset pointers carry no data; later bytes are dropped
    wire       ptr_wr  = ptr_ok & (ptr_cmd != `GDAC_CMD_RST_ALL) & (ptr_cmd != `GDAC_CMD_RST_ONE);

    // Ack: call address always, call data only if reset
    wire ack = ph_addr ? (addr_dev | addr_gc) :
               ph_gc   ? gc_ok : 1'b1;

    // Full word: high byte then low byte
    wire [15:0] word = {msb_byte, shift};
    wire [`GDAC_CODE_W-1:0] new_code = word[`GDAC_CODE_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Channel actions, each a one-cycle strobe at byte_end or, for copy_all, at a latch pin fall

    // General call reset acts as a power cycle
    wire gc_reset  = byte_end & ph_gc & gc_ok;
    wire rst_all   = byte_end & ph_ptr & new_ok & (new_cmd == `GDAC_CMD_RST_ALL);
    wire rst_one   = byte_end & ph_ptr & new_ok & (new_cmd == `GDAC_CMD_RST_ONE);
    wire data_wr   = byte_end & ph_lsb & ptr_wr;

    // Software update only while the latch pin holds
    wire sw_update = data_wr & link.latch & word[`GDAC_UPD_BIT];

    // Copy all storage into output registers
    wire copy_all  = link.latch_fall | sw_update;

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the bit-level machine

    always_comb begin
        next_state = state;
        unique case (state)
            gdac_pkg::GDAC_ST_IDLE: begin
                next_state = gdac_pkg::GDAC_ST_IDLE;      // Waits for a start
            end
            gdac_pkg::GDAC_ST_RX: begin
                if (byte_end) begin
                    // Not addressed: silent until the next start
                    next_state = ack ? gdac_pkg::GDAC_ST_ACK : gdac_pkg::GDAC_ST_SKIP;
                end
            end
            gdac_pkg::GDAC_ST_ACK: begin
                if (link.scl_fall) begin
                    next_state = gdac_pkg::GDAC_ST_RX;    // Ninth clock over
                end
            end
            gdac_pkg::GDAC_ST_SKIP: begin
                next_state = gdac_pkg::GDAC_ST_SKIP;
            end
        endcase

        // Start restarts from any state, stop ends the frame
        if (link.start) begin
            next_state = gdac_pkg::GDAC_ST_RX;
        end else if (link.stop) begin
            next_state = gdac_pkg::GDAC_ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Role of the next byte,
    // taken once this one is acked

    always_comb begin
        next_phase = phase;
        unique case (phase)
            gdac_pkg::GDAC_PH_ADDR: next_phase = addr_gc ? gdac_pkg::GDAC_PH_GC : gdac_pkg::GDAC_PH_PTR;
            gdac_pkg::GDAC_PH_GC:   next_phase = gdac_pkg::GDAC_PH_GC;
            gdac_pkg::GDAC_PH_PTR:  next_phase = gdac_pkg::GDAC_PH_MSB;
            gdac_pkg::GDAC_PH_MSB:  next_phase = gdac_pkg::GDAC_PH_LSB;
            gdac_pkg::GDAC_PH_LSB:  next_phase = gdac_pkg::GDAC_PH_MSB;
            default:                next_phase = gdac_pkg::GDAC_PH_ADDR;  // Codes 5..7 unused
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // reset to idle

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= gdac_pkg::GDAC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase register:
    // a start always expects an address byte

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || link.start) begin
            phase <= gdac_pkg::GDAC_PH_ADDR;
        end else if ((state == gdac_pkg::GDAC_ST_ACK) && link.scl_fall) begin
            phase <= next_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter and shift register;
    // data sampled on the clock rise

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || link.start) begin
            bit_cnt <= 4'h0;
        end else if ((state == gdac_pkg::GDAC_ST_ACK) && link.scl_fall) begin
            bit_cnt <= 4'h0;
        end else if ((state == gdac_pkg::GDAC_ST_RX) && link.scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shift <= 8'h00;
        end else if ((state == gdac_pkg::GDAC_ST_RX) && link.scl_rise) begin
            shift <= {shift[6:0], link.sda};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer and high byte.
    // The index steps after each word,
    // so a burst fills consecutive channels.

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || gc_reset) begin
            pointer <= 8'h00;
        end else if (byte_end && ph_ptr) begin
            pointer <= shift;
        end else if (byte_end && ph_lsb) begin
            pointer <= {pointer[7:5], ptr_sel + 5'h01};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            msb_byte <= 8'h00;
        end else if (byte_end && ph_msb) begin
            msb_byte <= shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ack drive: low from the end of bit eight
    // to the end of bit nine.
    // The clock line is never driven.

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || link.start || link.stop) begin
            sda_oe <= 1'b0;
        end else if (byte_end && ack) begin
            sda_oe <= 1'b1;
        end else if ((state == gdac_pkg::GDAC_ST_ACK) && link.scl_fall) begin
            sda_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel bank: storage and output register
    // per channel. Each channel has its own select,
    // so gamma and common channels are written
    // independently; copy_all updates both groups at once.

    genvar ch;
    generate
        for (ch = 0; ch < `GDAC_CHANNELS; ch = ch + 1) begin : g_chan

            // This channel is the one addressed by the pointer
            wire hit_wr  = data_wr & (ptr_sel == 5'(ch));
            wire hit_rst = rst_one & (new_sel == 5'(ch));
            // Any reset of this channel; it ignores the latch pin
            wire do_rst  = gc_reset | rst_all | hit_rst;

            // Value that storage will hold after this cycle
            wire [`GDAC_CODE_W-1:0] new_store = hit_wr ? new_code : store[ch];

            // Storage register
            always_ff @(posedge i_ref_clk) begin
                if (i_rst || do_rst) begin
                    store[ch] <= `GDAC_MIDSCALE;
                end else if (hit_wr) begin
                    store[ch] <= new_code;
                end
            end

            // Output register; an update word reaches
            // outputs with the storage it fills
            always_ff @(posedge i_ref_clk) begin
                if (i_rst || do_rst) begin
                    outreg[ch] <= `GDAC_MIDSCALE;
                end else if (hit_wr && !link.latch) begin
                    outreg[ch] <= new_code;
                end else if (copy_all) begin
                    outreg[ch] <= new_store;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, straight from flip-flops.
    // Converters scale codes linearly,
    // one step being span/1024.

    assign o_dac_code = outreg;

    assign o_sda_oe   = sda_oe;

    // Open-drain: the data value is a constant low register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sda_o <= 1'b0;
        end else begin
            o_sda_o <= 1'b0;
        end
    end

endmodule : gdac_update_control

// >>> verilog/gdac_regs.svh
// Constants of the gamma DAC update control block.
// Assumes inclusion by bare name wherever a constant is needed.
//
// Functional notes
// - Eighteen gamma plus two common channels, 10-bit
// - Storage register and separate output register each
// - General call 00h then 06h: full reset
// - Always ack 00h; nack other call data
// - Power-up reset drives all channels midscale
// - Pointer top bits 100: reset all midscale; the code does this only with the channel select below 20
// - Pointer top bits 010: reset one channel
// - Output code linear: low plus code span/1024
// - Latch pin low: output follows each write
// - Latch pin high holds; falling copies all
// - Bit 15 set: update all after word
// - Resets update outputs regardless of latch pin
// - Respond on serial bus at address 74h
// - Common channels written independently of gamma ones
// - Slave only; clock line is input only
// - Standard, fast and high-speed modes supported
`ifndef GDAC_REGS_SVH
`define GDAC_REGS_SVH

`define GDAC_CHANNELS      20          // Total DAC channels
`define GDAC_GAMMA_CHANS   18          // Gamma channels, indices 0..17
`define GDAC_CODE_W        10          // Code width per channel
`define GDAC_MIDSCALE      10'h200     // Reset code, half of span
`define GDAC_DEV_ADDR      8'h74       // Write address byte of this slave
`define GDAC_GC_ADDR       8'h00       // General call address byte
`define GDAC_GC_RESET      8'h06       // General call reset data byte
`define GDAC_CMD_HI        7           // Pointer command field, top bit
`define GDAC_CMD_LO        5           // Pointer command field, bottom bit
`define GDAC_CMD_RST_ALL   3'h4        // Pointer command: reset all channels
`define GDAC_CMD_RST_ONE   3'h2        // Pointer command: reset selected channel
`define GDAC_SEL_HI        4           // Pointer channel select, top bit
`define GDAC_UPD_BIT       15          // Word bit requesting update of all
`define GDAC_BYTE_BITS     4'h8        // Data bits per byte on the link

`endif

// >>> verilog/gdac_pkg.sv
// Types shared by the gamma DAC update control block.
// Assumes gdac_regs.svh supplies the numeric constants.
`include "gdac_regs.svh"

package gdac_pkg;

    // One channel code
    typedef logic [`GDAC_CODE_W-1:0] gdac_code_type;

    // Whole bank of channel codes, channel 0 in the low bits
    typedef gdac_code_type [`GDAC_CHANNELS-1:0] gdac_bank_type;

    // Synchronised link events and levels
    typedef struct packed {
        logic scl_rise;     // Clock line rising edge seen
        logic scl_fall;     // Clock line falling edge seen
        logic start;        // Start or repeated start
        logic stop;         // Stop condition
        logic sda;          // Synchronised data level
        logic latch_fall;   // Latch pin went from high to low
        logic latch;        // Synchronised latch pin level
    } gdac_link_type;

    // Bit-level slave state
    typedef enum logic [1:0] {
        GDAC_ST_IDLE = 2'b00,
        GDAC_ST_RX   = 2'b01,
        GDAC_ST_ACK  = 2'b10,
        GDAC_ST_SKIP = 2'b11
    } gdac_state_type;

    // Meaning of the byte now being received
    typedef enum logic [2:0] {
        GDAC_PH_ADDR = 3'b000,
        GDAC_PH_GC   = 3'b001,
        GDAC_PH_PTR  = 3'b010,
        GDAC_PH_MSB  = 3'b011,
        GDAC_PH_LSB  = 3'b100
    } gdac_phase_type;

endpackage : gdac_pkg

// >>> verilog/gdac_link_rx.sv
// Link front end: syncs clock, data and latch pins, finds their edges.
// Assumes asynchronous inputs whose levels last three clocks or more.
`timescale 1ns/100ps
`include "gdac_regs.svh"

module gdac_link_rx (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    input  wire logic                  i_latch_load_pin,
    output gdac_pkg::gdac_link_type    o_link
);

    logic [2:0] meta;     // First synchroniser stage: scl, sda, latch
    logic [2:0] sync;     // Second stage, safe to use
    logic [2:0] prev;     // Previous synchronised value for edges

    ////////////////////////////////////////////////////////////////////////////
    // Three flip-flops per pin, two of them synchronising; only sync reads meta
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta <= 3'h7;
            sync <= 3'h7;
            prev <= 3'h7;
        end else begin
            meta <= {i_latch_load_pin, i_sda, i_scl};
            sync <= meta;
            prev <= sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge and condition decode; the clock line is only ever sampled
    assign o_link.scl_rise   = sync[0] & ~prev[0];
    assign o_link.scl_fall   = ~sync[0] & prev[0];
    // Data moving while clock high marks start or stop
    assign o_link.start      = sync[0] & prev[0] & prev[1] & ~sync[1];
    assign o_link.stop       = sync[0] & prev[0] & ~prev[1] & sync[1];
    assign o_link.sda        = sync[1];
    assign o_link.latch_fall = prev[2] & ~sync[2];
    assign o_link.latch      = sync[2];

endmodule : gdac_link_rx

// >>> test/gdac_master_model.sv
// Two-wire master model: clocks the link, drives data open-drain.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
module gdac_master_model (
    input  wire logic i_ref_clk,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_low
);
    // Idle bus: clock stands high, data released
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // Lines change only just after a reference edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : tick
    // Start: data falls while the clock is high
    task automatic start;
        o_sda_low <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(1);
    endtask : start
    // Stop: data rises while the clock is high
    task automatic stop;
        o_sda_low <= 1'b1;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        o_sda_low <= 1'b0;
        tick(4);
    endtask : stop
    // One 200 ns bit, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        o_sda_low <= ~b;
        tick(4);
        o_scl <= 1'b1;
        tick(2);
        s = i_sda_line;
        tick(1);
        o_scl <= 1'b0;
        tick(1);
    endtask : bit_io
    // Byte MSB first, then the ack bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : send_byte
endmodule : gdac_master_model

// >>> test/gdac_update_control_asserts.sv
// Checker on the top ports of the gamma DAC update control block.
// Assumes one reference clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`include "gdac_regs.svh"
module gdac_update_control_asserts (
    input wire logic                    i_ref_clk,
    input wire logic                    i_rst,
    input wire logic                    i_scl,
    input wire logic                    i_sda,
    input wire logic                    i_latch_load_pin,
    input wire logic                    o_sda_o,
    input wire logic                    o_sda_oe,
    input wire gdac_pkg::gdac_bank_type o_dac_code
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    localparam gdac_pkg::gdac_bank_type MID = {20{`GDAC_MIDSCALE}};
    logic       scl_q;   // Clock line one cycle ago
    logic [3:0] scl_age; // Cycles since a clock line edge, saturating
    logic [3:0] low_len; // Cycles the latch pin has stayed low, saturating
    // Ages saturate so an old event never looks recent
    always_ff @(posedge i_ref_clk) begin
        scl_q   <= i_scl;
        if (i_rst) begin
            scl_age <= 4'hF;
            low_len <= 4'h0;
        end else begin
            scl_age <= (i_scl != scl_q) ? 4'h0 : scl_age + {3'h0, scl_age != 4'hF};
            low_len <= i_latch_load_pin ? 4'h0 : low_len + {3'h0, low_len != 4'hF};
        end
    end
    // True when exactly one channel differs
    function automatic bit one_ch(input gdac_pkg::gdac_bank_type a, input gdac_pkg::gdac_bank_type b);
        int n;
        n = 0;
        for (int k = 0; k < 20; k++) begin
            n += int'(a[k] != b[k]);
        end
        return n == 1;
    endfunction : one_ch
    property p_reset_mid;
        $fell(i_rst) |-> o_dac_code == MID && !o_sda_oe ##1 o_dac_code == MID;
    endproperty
    a_reset_mid: assert property (p_reset_mid) else $error("Bank not midscale after reset");
    property p_code_cause;
        o_dac_code != $past(o_dac_code) |-> scl_age <= 4'h9 || (low_len != 4'h0 && low_len <= 4'h8);
    endproperty
    a_code_cause: assert property (p_code_cause) else $error("Bank moved with no link or latch event");
    property p_latch_low_single;
        low_len >= 4'h8 && o_dac_code != $past(o_dac_code) |-> one_ch(o_dac_code, $past(o_dac_code)) || o_dac_code == MID;
    endproperty
    a_latch_low_single: assert property (p_latch_low_single) else $error("Direct write moved many channels");
    property p_idle_quiet;
        scl_age == 4'hF && (low_len == 4'h0 || low_len == 4'hF) |-> $stable(o_dac_code);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Bank moved on an idle bus");
    property p_ack_rise;
        $rose(o_sda_oe) |-> scl_age inside {[1:7]};
    endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("Ack not right after a clock fall");
    property p_ack_fall;
        $fell(o_sda_oe) |-> $past(o_sda_oe, 4);
    endproperty
    a_ack_fall: assert property (p_ack_fall) else $error("Ack released too early");
    property p_ack_hold;
        o_sda_oe && $rose(i_scl) |-> o_sda_oe [*3];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("Ack dropped in clock high");
    property p_ack_low;
        o_sda_oe |-> o_sda_o == 1'b0;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("Data driven high");
    c_ack: cover property ($rose(o_sda_oe));
    c_latch: cover property (low_len == 4'h1 ##[1:6] !$stable(o_dac_code));
    c_mid: cover property (!$stable(o_dac_code) && o_dac_code == MID);
endmodule : gdac_update_control_asserts
bind gdac_update_control gdac_update_control_asserts i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(i_scl),
    .i_sda(i_sda), .i_latch_load_pin(i_latch_load_pin), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_dac_code(o_dac_code));

// >>> test/gdac_update_control_bench.sv
// Self-checking bench for the gamma DAC update control block.
// Assumes a pull-up holds a released data line high.
`timescale 1ns/100ps
`include "gdac_regs.svh"
module gdac_update_control_bench;
    localparam gdac_pkg::gdac_bank_type MID = {20{`GDAC_MIDSCALE}};
    logic                    ref_clk = 1'b0; // 40 MHz reference
    logic                    rst     = 1'b1; // Power-up reset
    logic                    lat     = 1'b1; // Latch pin level
    logic                    scl;            // Clock line from master
    logic                    m_low;          // Master pulls data low
    logic                    dut_o;          // Block data value
    logic                    dut_oe;         // Block drives data
    gdac_pkg::gdac_bank_type code;           // Output registers seen
    wire                     sda = ~m_low & (~dut_oe | dut_o); // Pull-up wins when released
    gdac_pkg::gdac_bank_type st;             // Storage model
    gdac_pkg::gdac_bank_type ex;             // Output model
    gdac_pkg::gdac_bank_type last;           // Last noted bank
    gdac_pkg::gdac_bank_type seen;           // Last bank watched
    gdac_pkg::gdac_bank_type q [$];          // Expected banks, oldest first
    int                      fail_count = 0;
    int                      checks     = 0;
    int                      cyc        = 0;
    logic                    ack;
    always #12.5 ref_clk = ~ref_clk;
    gdac_master_model i_master (.i_ref_clk(ref_clk), .i_sda_line(sda), .o_scl(scl), .o_sda_low(m_low));
    gdac_update_control i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .i_latch_load_pin(lat), .o_sda_o(dut_o), .o_sda_oe(dut_oe), .o_dac_code(code));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [199:0] got, input logic [199:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic summarize;
        check("pending notes", q.size(), 0);
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // Queue the bank only when it changes; only changes are watched
    task automatic note;
        if (ex !== last)
            q.push_back(ex);
        last = ex;
    endtask : note
    task automatic mid_all;
        st = MID;
        ex = MID;
    endtask : mid_all
    // Latch pin change; a fall copies every channel
    task automatic set_lat(input logic v);
        if (lat && !v) begin
            ex = st;
            note();
        end
        @(posedge ref_clk);
        lat <= v;
        repeat (8) @(posedge ref_clk);
    endtask : set_lat
    // Frame to this slave; the model is noted before the acting byte
    task automatic wr(input logic [7:0] ptr, input int n, input logic upd);
        logic [7:0] hi;
        logic [7:0] lo;
        int         ch;
        i_master.start();
        i_master.send_byte(`GDAC_DEV_ADDR, ack);
        check("address ack", ack, 1'b1);
        if (ptr[7:5] == `GDAC_CMD_RST_ALL)
            mid_all();
        else if (ptr[7:5] == `GDAC_CMD_RST_ONE && ptr[4:0] < 5'h14) begin
            st[ptr[4:0]] = `GDAC_MIDSCALE;
            ex[ptr[4:0]] = `GDAC_MIDSCALE;
        end
        note();
        i_master.send_byte(ptr, ack);
        check("pointer ack", ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            hi = {upd && i == n - 1, 7'($urandom)};
            lo = 8'($urandom);
            ch = int'(ptr[4:0]) + i;
            if (ptr[7:5] != `GDAC_CMD_RST_ALL && ptr[7:5] != `GDAC_CMD_RST_ONE && ch < 20) begin
                st[ch] = {hi[1:0], lo};
                if (!lat)
                    ex[ch] = st[ch];
                else if (hi[7])
                    ex = st;
                note();
            end
            i_master.send_byte(hi, ack);
            i_master.send_byte(lo, ack);
            check("data ack", ack, 1'b1);
        end
        i_master.stop();
    endtask : wr
    // General call with a chosen data byte
    task automatic gcall(input logic [7:0] d);
        i_master.start();
        i_master.send_byte(`GDAC_GC_ADDR, ack);
        check("call address ack", ack, 1'b1);
        if (d == `GDAC_GC_RESET)
            mid_all();
        note();
        i_master.send_byte(d, ack);
        check("call data ack", ack, d == `GDAC_GC_RESET);
        i_master.stop();
    endtask : gcall
    ////////////////////////////////////////////////////////////////
    // Watcher: each bank change takes the oldest note
    always @(negedge ref_clk) begin
        if (rst)
            seen = code;
        else if (code !== seen) begin
            seen = code;
            if (q.size() == 0)
                check("unexpected bank", code, last);
            else
                check("dac bank", code, q.pop_front());
        end
    end
    // Hang guard, well above the run length
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        void'($urandom(67160));
        mid_all();
        last = MID;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("reset bank", code, MID);
        set_lat(1'b0);
        wr(8'h11, 3, 1'b0);
        set_lat(1'b1);
        wr(8'h00, 20, 1'b0);
        set_lat(1'b0);
        set_lat(1'b1);
        wr(8'h00, 18, 1'b0);
        wr(8'h12, 1, 1'b1);
        wr(8'h43, 0, 1'b0);
        wr(8'h1A, 2, 1'b1);
        wr(8'h05, 1, 1'b1);
        wr(8'h80, 1, 1'b0);
        wr(8'h00, 4, 1'b1);
        gcall(8'h07);
        gcall(8'h06);
        for (int j = 0; j < 3; j++) begin
            i_master.start();
            i_master.send_byte(j == 0 ? 8'h75 : (j == 1 ? 8'h76 : 8'hE8), ack);
            check("foreign address ack", ack, 1'b0);
            i_master.send_byte(8'($urandom), ack);
            check("ignored byte ack", ack, 1'b0);
            i_master.stop();
        end
        wr(8'h02, 2, 1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        mid_all();
        last = MID;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("second reset bank", code, MID);
        summarize();
    end
endmodule : gdac_update_control_bench
